/* File: core/bip_port.sv */
// Bidirectional I/O port block: four 8-bit port files behind an Avalon-MM slave.
// Assumes one clock mclk (40 MHz), async active-low reset, external TTL on pins.
//
// Behaviour
// - The direction write copies the data into the addressed port's tri-state latch unless that port is output-only; a one floats that pin.
// - A port other than an output-only one, modified as a function of itself, uses the pin levels, so a high latch pulled low is rewritten low.
// - An output-only port reads back its output latch instead of the pins.
// - Each pin's direction is chosen on its own, independent of the other bits.
// - Output values sit in the output latch and stay until software writes that latch again.
// - Inputs are not latched; a read captures the pins through the two-flop synchroniser, as they stood two mclk edges earlier.
// - A pin is floated before use as input, which drops the drivers and enables its pull-up.
// - Bit clear and bit set read the whole port, change one bit and write the whole port back.
// - A bit's pull-up is off whenever that bit is an output.
`timescale 1ns/1ps
module bip_port
  import bip_pkg::*;
#(
  parameter logic [BIP_NPORT-1:0] OUT_ONLY = 4'h0,
  parameter logic [BIP_NPORT-1:0] HAS_PULLUP = 4'hf
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [BIP_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pin_i,
  output logic [BIP_NPORT-1:0][BIP_W-1:0] pin_o,
  output logic [BIP_NPORT-1:0][BIP_W-1:0] pin_oe_n,
  output logic [BIP_NPORT-1:0][BIP_W-1:0] pullup_en
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access: read data is sampled in the first cycle,
  // writes take effect at the edge where waitrequest is seen low.
  bip_bus_st_t st_q;
  bip_bus_st_t st_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire req = avs_read | avs_write;
  wire commit_wr = avs_write & (st_q == BIP_ST_DONE);
  wire lane0 = avs_byteenable[0];

  always_comb
  begin
    case (st_q)
      BIP_ST_IDLE: st_d = req ? BIP_ST_DONE : BIP_ST_IDLE;
      BIP_ST_DONE: st_d = BIP_ST_IDLE;
      default: st_d = BIP_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= BIP_ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      wait_q <= (st_d != BIP_ST_DONE);
      if (avs_read && st_q == BIP_ST_IDLE)
        rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Decode and port cells
  // ----------------------------------------------------------------
  logic [BIP_NPORT-1:0][BIP_W-1:0] pin_sync;
  logic [BIP_NPORT-1:0][BIP_W-1:0] rd_port;
  logic [BIP_NPORT-1:0] hit_data;
  logic [BIP_NPORT-1:0] hit_dir;
  logic [BIP_NPORT-1:0] hit_bitop;
  wire [2:0] bit_sel = avs_writedata[BIP_BITOP_SEL_LSB +: 3];
  wire bit_set = avs_writedata[BIP_BITOP_SET_POS];
  wire [BIP_W-1:0] bit_mask = 8'h01 << bit_sel;

  genvar p;
  generate
    for (p = 0; p < BIP_NPORT; p = p + 1)
    begin : g_port
      bip_cell_ctl_t ctl;
      wire [BIP_W-1:0] rmw_val;

      assign hit_data[p] = (avs_address == {BIP_FILE_IDX[p], 2'b00});
      assign hit_dir[p] = (avs_address == BIP_DIR_BASE + 8'(4 * p));
      assign hit_bitop[p] = (avs_address == BIP_BITOP_BASE + 8'(4 * p));

      // Output-only port reads its latch, others the pins
      assign rd_port[p] = OUT_ONLY[p] ? pin_o[p] : pin_sync[p];
      // Whole port read, one bit changed, whole port rewritten
      assign rmw_val = bit_set ? (rd_port[p] | bit_mask)
                               : (rd_port[p] & ~bit_mask);

      assign ctl.latch_we = commit_wr & lane0 & (hit_data[p] | hit_bitop[p]);
      assign ctl.latch_val = hit_bitop[p] ? rmw_val : avs_writedata[BIP_W-1:0];
      // Output-only ports ignore direction writes
      assign ctl.dir_we = commit_wr & lane0 & hit_dir[p] & ~OUT_ONLY[p];
      assign ctl.dir_val = avs_writedata[BIP_W-1:0];

      bip_port_cell #(
        .HAS_PULLUP(HAS_PULLUP[p])
      ) u_cell (
        .mclk(mclk),
        .rst_n(rst_n),
        .ctl(ctl),
        .pin_i(pin_i[p]),
        .pin_o(pin_o[p]),
        .pin_oe_n(pin_oe_n[p]),
        .pullup_en(pullup_en[p]),
        .pin_sync(pin_sync[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped addresses read zero; reserved upper bits read zero.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < BIP_NPORT; i++)
    begin
      if (hit_data[i])
        rdata_d = {24'h000000, rd_port[i]};
      if (hit_dir[i])
        rdata_d = {24'h000000, pin_oe_n[i]};
      if (hit_bitop[i])
        rdata_d = {24'h000000, pin_o[i]};
    end
  end

endmodule // bip_port

/* File: core/bip_pkg.sv */
// Package for the bidirectional I/O port block: map, field layout, reset values.
// Assumes one 40 MHz clock and an Avalon-MM slave with 32-bit data.
package bip_pkg;

  localparam int BIP_NPORT = 4;
  localparam int BIP_W = 8;
  localparam int BIP_AW = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses; port files sit at four times index)
  // ----------------------------------------------------------------
  localparam logic [5:0] BIP_FILE_IDX [BIP_NPORT] = '{6'h05, 6'h06, 6'h07, 6'h08};
  localparam logic [BIP_AW-1:0] BIP_DIR_BASE = 8'h40;
  localparam logic [BIP_AW-1:0] BIP_BITOP_BASE = 8'h60;

  // Bit-op write fields
  localparam int BIP_BITOP_SEL_LSB = 0;
  localparam int BIP_BITOP_SET_POS = 3;

  // Reset values
  localparam logic [BIP_W-1:0] BIP_LATCH_RST = 8'h00;
  localparam logic [BIP_W-1:0] BIP_DIR_RST = 8'hff;

  // Timing: mclk period in nanoseconds, one cycle of the 40 MHz clock
  localparam int BIP_CLK_NS = 25;

  typedef enum logic {
    BIP_ST_IDLE = 1'b0,
    BIP_ST_DONE = 1'b1
  } bip_bus_st_t;

  // Write strobes into one port cell
  typedef struct packed {
    logic latch_we;
    logic dir_we;
    logic [BIP_W-1:0] latch_val;
    logic [BIP_W-1:0] dir_val;
  } bip_cell_ctl_t;

endpackage

/* File: core/bip_port_cell.sv */
// One 8-bit bidirectional port: output latch, tri-state latch, pin synchroniser.
// Assumes pins are asynchronous to mclk; write strobes come from the bus slave.
`timescale 1ns/1ps
module bip_port_cell
  import bip_pkg::*;
#(
  parameter logic HAS_PULLUP = 1'b1
)(
  input wire logic mclk,
  input wire logic rst_n,
  input bip_cell_ctl_t ctl,
  input wire logic [BIP_W-1:0] pin_i,
  output logic [BIP_W-1:0] pin_o,
  output logic [BIP_W-1:0] pin_oe_n,
  output logic [BIP_W-1:0] pullup_en,
  output logic [BIP_W-1:0] pin_sync
);

  logic [BIP_W-1:0] meta_q;
  logic [BIP_W-1:0] sync_q;
  logic [BIP_W-1:0] latch_q;
  logic [BIP_W-1:0] dir_q;
  logic [BIP_W-1:0] pullup_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      latch_q <= BIP_LATCH_RST;
      dir_q <= BIP_DIR_RST;
      pullup_q <= {BIP_W{HAS_PULLUP}};
    end
    else
    begin
      // No input latch: value follows the pins every cycle
      meta_q <= pin_i;
      sync_q <= meta_q;
      if (ctl.latch_we)
        latch_q <= ctl.latch_val;
      if (ctl.dir_we)
      begin
        dir_q <= ctl.dir_val;
        pullup_q <= ctl.dir_val & {BIP_W{HAS_PULLUP}};
      end
    end
  end

  assign pin_o = latch_q;
  assign pin_oe_n = dir_q;
  assign pullup_en = pullup_q;
  assign pin_sync = sync_q;

endmodule // bip_port_cell

/* File: tb/bip_port_asserts.sv */
// Checker for bip_port handshake and pin latches.
// Assumes OUT_ONLY[0] clear.
`timescale 1ns/1ps
module bip_port_asserts
  import bip_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [BIP_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pin_o,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pin_oe_n,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pullup_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire req = avs_read | avs_write;
  wire cmt = avs_write & ~avs_waitrequest & avs_byteenable[0];
  property p_wait1; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait1: assert property (p_wait1) else $error("no answer");
  property p_back; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_back: assert property (p_back) else $error("wait stuck low");
  property p_idle; !req |-> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("idle wait low");
  property p_hold; !$past(cmt) |-> $stable(pin_o) && $stable(pin_oe_n); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_dir; cmt && avs_address == BIP_DIR_BASE |=> pin_oe_n[0] == $past(avs_writedata[7:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("dir lost");
  property p_dat; cmt && avs_address == {BIP_FILE_IDX[0], 2'b00}
    |=> pin_o[0] == $past(avs_writedata[7:0]); endproperty
  a_dat: assert property (p_dat) else $error("data lost");
  property p_pull; (pullup_en & ~pin_oe_n) == '0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on output");
  property p_rst; $rose(rst_n) |-> &pin_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("pin driven");
  c_wr: cover property (cmt);
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_rst: cover property ($rose(rst_n));
endmodule // bip_port_asserts
bind bip_port bip_port_asserts u_bip_port_asserts (.mclk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .pin_o, .pin_oe_n, .pullup_en);

/* File: tb/bip_pin_model.sv */
// Outside logic on the port pins.
// Assumes the bench picks which pins it drives.
`timescale 1ns/1ps
module bip_pin_model
  import bip_pkg::*;
(
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pin_o,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pin_oe_n,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] pullup_en,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] ext_en,
  input wire logic [BIP_NPORT-1:0][BIP_W-1:0] ext_val,
  output logic [BIP_NPORT-1:0][BIP_W-1:0] pin_i
);
  // Outside drive wins; floating pin without pull-up flips
  assign pin_i = (ext_en & ext_val) | (~ext_en & ~pin_oe_n & pin_o)
    | (~ext_en & pin_oe_n & (pullup_en | ~pin_o));
endmodule // bip_pin_model

/* File: tb/bidir_io_port_rmw_tb.sv */
// Bench for bip_port over Avalon-MM with a pin model.
// Assumes port 1 is output only.
`timescale 1ns/1ps
module bidir_io_port_rmw_tb
  import bip_pkg::*;
;
  typedef logic [BIP_NPORT-1:0][BIP_W-1:0] bip_pins_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  bip_pins_t pin_i, pin_o, pin_oe_n, pullup_en;
  bip_pins_t ext_en = '0;
  bip_pins_t ext_val = '0;
  logic [7:0] q;
  int num_errors = 0;
  int n_tests = 0;
  always #12.5 mclk = ~mclk;
  bip_port #(.OUT_ONLY(4'h2)) u_bip_port (.mclk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .pin_i, .pin_o, .pin_oe_n, .pullup_en);
  bip_pin_model u_bip_pin_model (.pin_o, .pin_oe_n, .pullup_en, .ext_en, .ext_val, .pin_i);
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, input logic [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d, 4'h1);
  endtask
  // Waits out the pin synchroniser before reading
  task automatic rd(input logic [7:0] a, e);
    repeat (3) @(posedge mclk);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(q, e);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h40, 8'hff);
    chk(pullup_en[0], 8'hff);
    rd(8'h80, 8'h00);
    wr(8'h40, 8'h0f);
    wr(8'h14, 8'ha5);
    bus(1'b1, 8'h14, 8'h00, 4'h0);
    rd(8'h40, 8'h0f);
    chk(pullup_en[0], 8'h0f);
    rd(8'h14, 8'haf);
    ext_en[0] <= 8'h0f;
    ext_val[0] <= 8'h06;
    rd(8'h14, 8'ha6);
    ext_val[0] <= 8'h09;
    rd(8'h14, 8'ha9);
    ext_en[0] <= 8'h8f;
    rd(8'h14, 8'h29);
    wr(8'h60, 8'h09);
    rd(8'h60, 8'h2b);
    wr(8'h60, 8'h05);
    rd(8'h60, 8'h09);
    ext_en[1] <= 8'hff;
    ext_val[1] <= 8'hff;
    wr(8'h18, 8'h3c);
    rd(8'h18, 8'h3c);
    // Direction write to the output-only port is refused
    wr(8'h44, 8'h00);
    rd(8'h44, 8'hff);
    // Whole port 3 as output: latch on the pins, pull-ups off
    wr(8'h4c, 8'h00);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h5a);
    chk(pullup_en[3], 8'h00);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(pin_oe_n[0], 8'hff);
    chk(pin_oe_n[3], 8'hff);
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    final_report;
  end
endmodule // bidir_io_port_rmw_tb
